// ### design/sstal_top.sv
// Servo status, torque limit and alarm logic with AXI4-Lite registers
// Functional notes
// RULE_01: Done flag only while enabled; timing follows in-position range.
// RULE_02: Near flag only while enabled; zero range tracks command finish.
// RULE_03: In-position: feedback error within range, only while enabled.
// RULE_04: Output torque always clamped to active forward or reverse limit.
// RULE_05: Select 0 uses quadrant limits; 1 uses secondary limit if smaller. Code uses it only when below both forward and reverse limits.
// RULE_06: Torque-limiting flag when torque reaches the selected limit.
// RULE_07: Any alarm immediately cuts power stage drive.
// RULE_08: Alarm cleared by power cycle, panel set key, or reset bit rising.
// RULE_09: Clears ignored while alarm cause persists; alarm stays latched.
// RULE_10: Undervoltage alarm when control power loss lasts 60 ms or more.
// RULE_11: Undervoltage alarm when enabled and bus voltage 200 V or below.
// RULE_12: Incremental mode loses home on any alarm; host must rehome.
// RULE_13: Encoder pulse period set by two output scaling settings.
// RULE_14: Host drops servo enable on alarm and resumes after reset.
// RULE_15: Host starts moves only after done, or near-target with zero range.
// RULE_16: Move starts on start command rising edge within 3 ms.
// RULE_17: Alarm code tells undervoltage, overcurrent, overload, regen apart.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module sstal_top
  import sstal_pkg::*;
#(
  parameter int unsigned UV_CNT    = sstal_pkg::UV_CYCLES,
  parameter int unsigned START_CNT = sstal_pkg::START_CYCLES
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  // AXI4-Lite write
  input  wire logic [7:0]              i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output logic [1:0]                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output logic [1:0]                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  // Motor side sensing
  input  wire sstal_pkg::sstal_sense_t i_sense,
  input  wire logic                    i_fb_step,
  // Drive outputs
  output logic signed [15:0]           o_torque,
  output logic                         o_drive_en,
  output logic                         o_move_start,
  output logic                         o_enc_pulse,
  output logic                         o_move_done_flag,
  output logic                         o_near_target_flag,
  output logic                         o_in_position_signal,
  output logic                         o_torque_limiting_flag,
  output logic                         o_alarm
);
  import sstal_pkg::*;

  typedef enum logic [2:0] {
    SSTAL_IDLE = 3'b001,
    SSTAL_WAIT = 3'b010,
    SSTAL_MOVE = 3'b100
  } sstal_state_t;

  // Sensing passes two flops; data words assumed stable per sample
  sstal_sense_t sense_m;
  sstal_sense_t sense;
  logic         step_m;
  logic         step_s;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sense_m <= '0;
      sense   <= '0;
      step_m  <= 1'b0;
      step_s  <= 1'b0;
    end else begin
      sense_m <= i_sense;
      sense   <= sense_m;
      step_m  <= i_fb_step;
      step_s  <= step_m;
    end
  end

  // Registers
  logic [6:0]  cmd;
  logic [15:0] inpos_rng;
  logic [15:0] near_rng;
  logic [15:0] fwd_lim;
  logic [15:0] rev_lim;
  logic [15:0] sec_lim;
  logic [15:0] scale_a;
  logic [15:0] scale_b;
  logic [6:0]  cmd_q;
  logic [6:0]  status;

  // AXI4-Lite write path
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire        aw_take = i_awvalid && o_awready;
  wire        w_take  = i_wvalid && o_wready;
  wire        wr_go   = aw_hold && w_hold && !o_bvalid;
  wire        wr_hit  = (aw_addr == ADDR_CMD) || (aw_addr == ADDR_INPOS) ||
                        (aw_addr == ADDR_NEAR) || (aw_addr == ADDR_FWDLIM) ||
                        (aw_addr == ADDR_REVLIM) || (aw_addr == ADDR_SECLIM) ||
                        (aw_addr == ADDR_SCALEA) || (aw_addr == ADDR_SCALEB);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold   <= 1'b1;
        aw_addr   <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_take) begin
        w_hold   <= 1'b1;
        w_data   <= i_wdata;
        w_strb   <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd       <= 7'h00;
      inpos_rng <= 16'h0000;
      near_rng  <= 16'h0000;
      fwd_lim   <= LIMIT_RST;
      rev_lim   <= LIMIT_RST;
      sec_lim   <= LIMIT_RST;
      scale_a   <= SCALE_RST;
      scale_b   <= SCALE_RST;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == ADDR_CMD) begin
        cmd <= w_data[6:0];
      end else if (aw_addr == ADDR_INPOS) begin
        inpos_rng <= merge16(inpos_rng, w_data, w_strb);
      end else if (aw_addr == ADDR_NEAR) begin
        near_rng <= merge16(near_rng, w_data, w_strb);
      end else if (aw_addr == ADDR_FWDLIM) begin
        fwd_lim <= merge16(fwd_lim, w_data, w_strb);
      end else if (aw_addr == ADDR_REVLIM) begin
        rev_lim <= merge16(rev_lim, w_data, w_strb);
      end else if (aw_addr == ADDR_SECLIM) begin
        sec_lim <= merge16(sec_lim, w_data, w_strb);
      end else if (aw_addr == ADDR_SCALEA) begin
        scale_a <= merge16(scale_a, w_data, w_strb);
      end else if (aw_addr == ADDR_SCALEB) begin
        scale_b <= merge16(scale_b, w_data, w_strb);
      end
    end
  end

  // AXI4-Lite read path
  sstal_alarm_t alarm_code;
  logic [31:0]  rd_mux;
  logic         rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (i_araddr == ADDR_CMD) begin
      rd_mux = {25'h0, cmd};
    end else if (i_araddr == ADDR_STATUS) begin
      rd_mux = {25'h0, status};
    end else if (i_araddr == ADDR_INPOS) begin
      rd_mux = {16'h0, inpos_rng};
    end else if (i_araddr == ADDR_NEAR) begin
      rd_mux = {16'h0, near_rng};
    end else if (i_araddr == ADDR_FWDLIM) begin
      rd_mux = {16'h0, fwd_lim};
    end else if (i_araddr == ADDR_REVLIM) begin
      rd_mux = {16'h0, rev_lim};
    end else if (i_araddr == ADDR_SECLIM) begin
      rd_mux = {16'h0, sec_lim};
    end else if (i_araddr == ADDR_SCALEA) begin
      rd_mux = {16'h0, scale_a};
    end else if (i_araddr == ADDR_SCALEB) begin
      rd_mux = {16'h0, scale_b};
    end else if (i_araddr == ADDR_ALCODE) begin
      rd_mux = {29'h0, alarm_code}; // RULE_17
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_mux;
      o_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Alarm causes; the first cause seen is the one latched
  logic [22:0] uv_cnt;
  wire uv_power = (uv_cnt >= 23'(UV_CNT)); // RULE_10
  wire uv_bus   = cmd[CMD_SERVO] && (sense.bus_volt <= UV_BUS_LIMIT); // RULE_11
  wire cause_uv = uv_power || uv_bus;
  sstal_alarm_t cause_code;
  assign cause_code = cause_uv          ? SSTAL_AL_UV    :
                      sense.fault_oc    ? SSTAL_AL_OC    :
                      sense.fault_ol1   ? SSTAL_AL_OL1   :
                      sense.fault_ol2   ? SSTAL_AL_OL2   :
                      sense.fault_regen ? SSTAL_AL_REGEN : SSTAL_AL_NONE;
  wire cause_any = (cause_code != SSTAL_AL_NONE);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      uv_cnt <= 23'h0;
    end else if (sense.ctrl_pwr_ok) begin
      uv_cnt <= 23'h0;
    end else if (!uv_power) begin
      uv_cnt <= uv_cnt + 23'h1;
    end
  end

  wire clr_edge = (cmd[CMD_CLRA] && !cmd_q[CMD_CLRA]) ||
                  (cmd[CMD_CLRB] && !cmd_q[CMD_CLRB]) ||
                  sense.panel_set; // RULE_08
  wire alarm_on = (alarm_code != SSTAL_AL_NONE);

  // Power cycle clears through i_arst_n; clear loses to a live cause
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_code <= SSTAL_AL_NONE;
    end else if (!alarm_on && cause_any) begin
      alarm_code <= cause_code;
    end else if (alarm_on && clr_edge && !cause_any) begin
      alarm_code <= SSTAL_AL_NONE; // RULE_09
    end
  end

  ahold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_09
    alarm_on && cause_any |=> alarm_on) else $error("alarm cleared early");
  clr_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_08
    alarm_on && clr_edge && !cause_any |=> !alarm_on)
    else $error("alarm not cleared");

  // Home position
  logic home_ok;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      home_ok <= 1'b0;
    end else if (cmd[CMD_INCR] && (alarm_on || cause_any)) begin
      home_ok <= 1'b0; // RULE_12
    end else if (sense.cmd_done && !alarm_on) begin
      home_ok <= 1'b1;
    end
  end

  // Start sequencer
  sstal_state_t state;
  logic [17:0]  st_cnt;
  wire start_edge = (cmd[CMD_FWD] && !cmd_q[CMD_FWD]) ||
                    (cmd[CMD_REV] && !cmd_q[CMD_REV]);
  wire enabled = cmd[CMD_SERVO] && !alarm_on;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state        <= SSTAL_IDLE;
      st_cnt       <= 18'h0;
      o_move_start <= 1'b0;
      cmd_q        <= 7'h00;
    end else begin
      cmd_q        <= cmd;
      o_move_start <= 1'b0;
      case (state)
        SSTAL_IDLE: begin
          if (start_edge && enabled) begin
            state  <= SSTAL_WAIT;
            st_cnt <= 18'h0;
          end
        end
        SSTAL_WAIT: begin
          if (!enabled) begin
            state <= SSTAL_IDLE;
          end else if (st_cnt >= 18'(START_CNT - 1)) begin
            state        <= SSTAL_MOVE;
            o_move_start <= 1'b1; // RULE_16
          end else begin
            st_cnt <= st_cnt + 18'h1;
          end
        end
        SSTAL_MOVE: begin
          if (!enabled || sense.cmd_done) begin
            state <= SSTAL_IDLE;
          end
        end
        default: state <= SSTAL_IDLE;
      endcase
    end
  end

  // Positioning flags
  wire signed [32:0] err = 33'(sense.pos_cmd) - 33'(sense.pos_fb);
  wire [32:0] abs_err = err[32] ? 33'(-err) : 33'(err);
  wire in_rng   = abs_err <= {17'h0, inpos_rng};
  wire near_rng_hit = (near_rng == 16'h0000) ? sense.cmd_done :
                      (abs_err <= {17'h0, near_rng});
  wire next_done = enabled && sense.cmd_done && in_rng;
  wire next_near = enabled && near_rng_hit;
  wire next_inp  = enabled && in_rng;

  // Torque limit selection by quadrant
  wire signed [15:0] trq = sense.torque_req;
  wire [15:0] quad_lim = trq[15] ? rev_lim : fwd_lim;
  wire sec_used = cmd[CMD_LIMSEL] && (sec_lim < fwd_lim) &&
                  (sec_lim < rev_lim); // RULE_05
  wire [15:0] act_lim = sec_used ? sec_lim : quad_lim;
  wire [15:0] mag = trq[15] ? 16'(-trq) : 16'(trq);
  wire at_lim = mag >= act_lim; // RULE_06
  wire signed [15:0] clamped = !at_lim ? trq :
                               (trq[15] ? 16'(-act_lim) : act_lim); // RULE_04

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_torque               <= 16'h0000;
      o_drive_en             <= 1'b0;
      o_move_done_flag       <= 1'b0;
      o_near_target_flag     <= 1'b0;
      o_in_position_signal   <= 1'b0;
      o_torque_limiting_flag <= 1'b0;
      o_alarm                <= 1'b0;
      status                 <= 7'h00;
    end else begin
      o_drive_en             <= enabled && !cause_any; // RULE_07
      o_torque               <= (enabled && !cause_any) ? clamped : 16'h0000;
      o_move_done_flag       <= next_done; // RULE_01
      o_near_target_flag     <= next_near; // RULE_02
      o_in_position_signal   <= next_inp; // RULE_03
      o_torque_limiting_flag <= enabled && at_lim;
      o_alarm                <= alarm_on || cause_any;
      status <= {state != SSTAL_IDLE, home_ok, alarm_on || cause_any,
                 enabled && at_lim, next_inp, next_near, next_done};
    end
  end

  cut_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_07
    cause_any |=> !o_drive_en && (o_torque == 16'h0000))
    else $error("drive not cut on alarm");
  clamp_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_04
    enabled && !cause_any && !at_lim |=> o_torque == $past(trq))
    else $error("torque changed below limit");
  flags_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_01
    !enabled |=> !o_move_done_flag && !o_near_target_flag &&
    !o_in_position_signal) else $error("flag while disabled");
  start_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    $rose(o_move_start) |-> $past(state == SSTAL_WAIT))
    else $error("start without wait");

  sstal_pulse_div sstal_pulse_div_inst (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_scale_a (scale_a),
    .i_scale_b (scale_b),
    .i_step    (step_s),
    .o_pulse   (o_enc_pulse)
  );
endmodule : sstal_top

// ### pkg/sstal_pkg.sv
// Package: register map, field layouts and constants of the servo status block
package sstal_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned UV_TIME_MS   = 60;
  localparam int unsigned UV_CYCLES    = CLK_HZ / 1000 * UV_TIME_MS;
  localparam int unsigned START_MS     = 3;
  localparam int unsigned START_CYCLES = CLK_HZ / 1000 * START_MS;

  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_INPOS   = 8'h08;
  localparam logic [7:0] ADDR_NEAR    = 8'h0C;
  localparam logic [7:0] ADDR_FWDLIM  = 8'h10;
  localparam logic [7:0] ADDR_REVLIM  = 8'h14;
  localparam logic [7:0] ADDR_SECLIM  = 8'h18;
  localparam logic [7:0] ADDR_SCALEA  = 8'h1C;
  localparam logic [7:0] ADDR_SCALEB  = 8'h20;
  localparam logic [7:0] ADDR_ALCODE  = 8'h24;

  // Command word bits
  localparam int unsigned CMD_SERVO  = 0;
  localparam int unsigned CMD_FWD    = 1;
  localparam int unsigned CMD_REV    = 2;
  localparam int unsigned CMD_LIMSEL = 3;
  localparam int unsigned CMD_CLRA   = 4;
  localparam int unsigned CMD_CLRB   = 5;
  localparam int unsigned CMD_INCR   = 6;

  // Status word bits
  localparam int unsigned ST_DONE  = 0;
  localparam int unsigned ST_NEAR  = 1;
  localparam int unsigned ST_INPOS = 2;
  localparam int unsigned ST_TLIM  = 3;
  localparam int unsigned ST_ALARM = 4;
  localparam int unsigned ST_HOME  = 5;
  localparam int unsigned ST_BUSY  = 6;

  localparam logic [15:0] UV_BUS_LIMIT = 16'h00C8;
  localparam logic [15:0] SCALE_RST    = 16'h0001;
  localparam logic [15:0] LIMIT_RST    = 16'h7FFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SSTAL_AL_NONE  = 3'h0,
    SSTAL_AL_UV    = 3'h1,
    SSTAL_AL_OC    = 3'h2,
    SSTAL_AL_OL1   = 3'h3,
    SSTAL_AL_OL2   = 3'h4,
    SSTAL_AL_REGEN = 3'h5
  } sstal_alarm_t;

  // Motor-side sensing bundle
  typedef struct packed {
    logic signed [31:0] pos_cmd;
    logic signed [31:0] pos_fb;
    logic signed [15:0] torque_req;
    logic [15:0]        bus_volt;
    logic               ctrl_pwr_ok;
    logic               fault_oc;
    logic               fault_ol1;
    logic               fault_ol2;
    logic               fault_regen;
    logic               cmd_done;
    logic               panel_set;
  } sstal_sense_t;
endpackage : sstal_pkg

// ### design/sstal_pulse_div.sv
// Encoder pulse output divider
`timescale 1ns/10ps
module sstal_pulse_div (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Scaling and motion
  input  wire logic [15:0] i_scale_a,
  input  wire logic [15:0] i_scale_b,
  input  wire logic        i_step,
  // Pulse out
  output logic             o_pulse
);
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [15:0] den;
  assign den = (i_scale_b == 16'h0000) ? 16'h0001 : i_scale_b;
  // Ratio a/b of feedback steps toggles the output, setting its period
  assign next_acc = i_step ? acc + {16'h0000, i_scale_a} : acc;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc     <= 32'h0000_0000;
      o_pulse <= 1'b0;
    end else if (next_acc >= {16'h0000, den}) begin
      acc     <= next_acc - {16'h0000, den}; // RULE_13
      o_pulse <= ~o_pulse;
    end else begin
      acc <= next_acc;
    end
  end
endmodule : sstal_pulse_div

// ### sim/sstal_host.sv
// Host controller model: AXI4-Lite master on the command link
`timescale 1ns/10ps
module sstal_host (
  // Clock
  input  wire logic        i_clk,
  // Write side
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  // Read side
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end

  // Released payload is inverted so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_awaddr  <= a;
    o_awvalid <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= 4'hF;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
    end while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
    end while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask : rd
endmodule : sstal_host

// ### sim/sstal_top_bench.sv
// Self-checking bench for the servo status, torque and alarm block
`timescale 1ns/10ps
module sstal_top_bench;
  import sstal_pkg::*;
  // Short counts keep the run brief
  localparam int unsigned UVN = 20;
  localparam int unsigned STN = 4;
  typedef struct packed {
    logic               sel;
    logic [15:0]        fwd, rev, sec;
    logic signed [15:0] req, exp;
    logic               tl;
  } sstal_row_t;
  localparam sstal_row_t ROWS [7] = '{
    '{1'b0, 16'h0100, 16'h0080, 16'h0040, 16'h0050, 16'h0050, 1'b0},
    '{1'b0, 16'h0100, 16'h0080, 16'h0040, 16'h0200, 16'h0100, 1'b1},
    '{1'b0, 16'h0100, 16'h0080, 16'h0040, 16'hFE00, 16'hFF80, 1'b1},
    '{1'b1, 16'h0100, 16'h0080, 16'h0040, 16'h0200, 16'h0040, 1'b1},
    '{1'b1, 16'h0100, 16'h0080, 16'h0180, 16'h0200, 16'h0100, 1'b1},
    '{1'b1, 16'h0100, 16'h0080, 16'h00C0, 16'h0200, 16'h0100, 1'b1},
    '{1'b1, 16'h0100, 16'h0080, 16'h0040, 16'hFE00, 16'hFFC0, 1'b1}};
  logic               i_clk, i_arst_n, fb_step, enc_q;
  logic [7:0]         awaddr, araddr;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [31:0]        wdata, rdata, rd_d;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, rsp;
  sstal_sense_t       sense;
  logic signed [15:0] torque;
  logic               drive_en, move_start, enc_pulse, alarm;
  logic               done_f, near_f, inpos_f, tlim_f;
  int                 error_cnt = 0, n_checks = 0, starts = 0, toggles = 0;
  int                 t0;

  sstal_host host_inst (.i_clk(i_clk), .o_awaddr(awaddr),
    .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
    .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
    .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

  sstal_top #(.UV_CNT(UVN), .START_CNT(STN)) sstal_top_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_sense(sense),
    .i_fb_step(fb_step), .o_torque(torque), .o_drive_en(drive_en),
    .o_move_start(move_start), .o_enc_pulse(enc_pulse),
    .o_move_done_flag(done_f), .o_near_target_flag(near_f),
    .o_in_position_signal(inpos_f), .o_torque_limiting_flag(tlim_f),
    .o_alarm(alarm));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    enc_q <= enc_pulse;
    if (move_start === 1'b1) starts <= starts + 1;
    if (enc_pulse !== enc_q) toggles <= toggles + 1;
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    host_inst.wr(a, d, rsp);
    check(rsp, RESP_OKAY, "bresp");
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host_inst.rd(a, rd_d, rsp);
    check(rd_d, e, "read data");
  endtask : rchk

  // Bits: 0 servo, 1 fwd, 2 rev, 3 limsel, 4 clear a, 5 clear b, 6 incr
  task automatic cmd(input logic [6:0] c);
    wreg(ADDR_CMD, {25'h0, c});
  endtask : cmd

  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    i_arst_n = 1'b0;
    fb_step  = 1'b0;
    sense    = '0;
    sense.ctrl_pwr_ok = 1'b1;
    sense.bus_volt    = 16'h0136;
    tick(6);
    i_arst_n <= 1'b1;
    tick(2);
    check({alarm, drive_en, torque}, 18'h0, "reset outputs");
    rchk(ADDR_FWDLIM, {16'h0, LIMIT_RST});
    rchk(ADDR_SCALEA, {16'h0, SCALE_RST});
    rchk(ADDR_INPOS, 32'h0);
    rchk(ADDR_ALCODE, 32'(SSTAL_AL_NONE));
    $display("test reset done");
    cmd(7'h01);
    foreach (ROWS[i]) begin
      wreg(ADDR_FWDLIM, {16'h0, ROWS[i].fwd});
      wreg(ADDR_REVLIM, {16'h0, ROWS[i].rev});
      wreg(ADDR_SECLIM, {16'h0, ROWS[i].sec});
      cmd({3'b000, ROWS[i].sel, 3'b001});
      sense.torque_req <= ROWS[i].req;
      tick(6);
      check(32'(torque), 32'(ROWS[i].exp), "torque");
      check(tlim_f, ROWS[i].tl, "limiting flag");
    end
    $display("test torque table done");
    wreg(ADDR_INPOS, 32'hFFFF0005);
    rchk(ADDR_INPOS, 32'h5);
    sense.pos_cmd  <= 32'sd1000;
    sense.pos_fb   <= 32'sd1005;
    sense.cmd_done <= 1'b1;
    tick(6);
    check({done_f, near_f, inpos_f}, 3'b111, "at target");
    sense.pos_fb <= 32'sd1006;
    tick(6);
    check({done_f, near_f, inpos_f}, 3'b010, "outside range");
    wreg(ADDR_NEAR, 32'h5);
    tick(6);
    check(near_f, 1'b0, "near miss");
    sense.pos_fb <= 32'sd1005;
    tick(6);
    check(near_f, 1'b1, "near hit");
    sense.pos_fb <= 32'sd1005;
    cmd(7'h00);
    tick(6);
    check({done_f, near_f, inpos_f}, 3'b000, "servo off");
    $display("test position flags done");
    cmd(7'h01);
    tick(6);
    check(done_f, 1'b1, "done before start");
    cmd(7'h03);
    tick(STN + 12);
    check(starts, 1, "fwd start");
    cmd(7'h03);
    cmd(7'h01);
    cmd(7'h05);
    tick(STN + 12);
    check(starts, 2, "rev start only");
    $display("test move start done");
    for (int s = 1; s <= 2; s++) begin
      wreg(ADDR_SCALEB, s);
      t0 = toggles;
      repeat (8) begin
        fb_step <= 1'b1;
        tick(1);
        fb_step <= 1'b0;
        tick(4);
      end
      tick(4);
      check(toggles - t0, 8 / s, "encoder toggles");
    end
    $display("test encoder done");
    for (int k = 0; k < 4; k++) begin
      cmd(7'h41);
      {sense.fault_oc, sense.fault_ol1, sense.fault_ol2,
       sense.fault_regen} <= 4'h8 >> k;
      tick(6);
      check({alarm, drive_en, torque}, 18'h20000, "drive cut");
      rchk(ADDR_ALCODE, 32'(SSTAL_AL_OC) + k);
      host_inst.rd(ADDR_STATUS, rd_d, rsp);
      check(rd_d[ST_HOME], 1'b0, "home lost");
      cmd(7'h40);
      cmd(7'h70);
      cmd(7'h40);
      tick(6);
      check(alarm, 1'b1, "clear with live cause");
      {sense.fault_oc, sense.fault_ol1, sense.fault_ol2,
       sense.fault_regen} <= 4'h0;
      tick(6);
      if (k == 2) begin
        sense.panel_set <= 1'b1;
        tick(4);
        sense.panel_set <= 1'b0;
      end else begin
        cmd(k == 1 ? 7'h60 : 7'h50);
        cmd(7'h40);
      end
      tick(6);
      check(alarm, 1'b0, "alarm cleared");
    end
    $display("test alarms done");
    cmd(7'h01);
    sense.ctrl_pwr_ok <= 1'b0;
    tick(UVN - 4);
    sense.ctrl_pwr_ok <= 1'b1;
    tick(6);
    check(alarm, 1'b0, "short dip");
    sense.ctrl_pwr_ok <= 1'b0;
    tick(UVN + 6);
    check(alarm, 1'b1, "long dip");
    rchk(ADDR_ALCODE, 32'(SSTAL_AL_UV));
    sense.ctrl_pwr_ok <= 1'b1;
    cmd(7'h00);
    cmd(7'h10);
    cmd(7'h01);
    sense.bus_volt <= UV_BUS_LIMIT + 16'h0001;
    tick(6);
    check(alarm, 1'b0, "bus above limit");
    sense.bus_volt <= UV_BUS_LIMIT;
    tick(6);
    check(alarm, 1'b1, "bus at limit");
    i_arst_n <= 1'b0;
    tick(2);
    i_arst_n <= 1'b1;
    tick(6);
    check(alarm, 1'b0, "power cycle");
    $display("test undervoltage done");
    host_inst.wr(8'h28, 32'h1, rsp);
    check(rsp, RESP_SLVERR, "unmapped write");
    host_inst.rd(8'h28, rd_d, rsp);
    check(rsp, RESP_SLVERR, "unmapped read");
    wreg(ADDR_SCALEB, 32'hABCD0003);
    rchk(ADDR_SCALEB, 32'h3);
    $display("test register map done");
    conclude();
  end
endmodule : sstal_top_bench
